// *** rtl/pdm_pkg.sv ***
// package of register map, field positions and timing constants for the power-mode controller
`default_nettype none
package pdm_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_TMR_MODE = 16'hFFA6;
  localparam logic [15:0] OFS_TMR_CNT  = 16'hFFA7;
  localparam logic [15:0] OFS_P7_DATA  = 16'hFFDA;
  localparam logic [15:0] OFS_P7_DIR   = 16'hFFEA;
  localparam logic [15:0] OFS_SYSCTL1  = 16'hFFF0;
  localparam logic [15:0] OFS_SYSCTL2  = 16'hFFF1;
  localparam logic [15:0] OFS_IRQ_EN1  = 16'hFFF4;
  localparam logic [15:0] OFS_IRQ_REQ1 = 16'hFFF6;
  localparam logic [15:0] OFS_CORE_CTL = 16'hFFF8;
  localparam logic [15:0] OFS_STATUS   = 16'hFFF9;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SC1_STANDBY_BIT   = 7;
  localparam int SC1_WAIT_HI       = 6;
  localparam int SC1_WAIT_LO       = 4;
  localparam int SC2_SLEEP_KIND    = 7;
  localparam int SC2_LOW_SPEED     = 6;
  localparam int SC2_DIRECT        = 5;
  localparam int SC2_ACLK_HI       = 4;
  localparam int SC2_ACLK_LO       = 2;
  localparam int SC2_SCLK_HI       = 1;
  localparam int SC2_SCLK_LO       = 0;
  localparam int IRQ_DT_BIT        = 7;
  localparam int IRQ_TA_BIT        = 6;
  localparam int P7_PIN4           = 4;
  localparam int CORE_SLEEP_BIT    = 0;
  localparam int CORE_IMASK_BIT    = 1;
  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] RST_CORE_CTL   = 8'h02;
  localparam logic [7:0] TMR_TIMEBASE   = 8'h19;
  localparam logic [2:0] WAIT_SEL_131K  = 3'h4;
  localparam logic [2:0] ACLK_UNDIVIDED = 3'h3;
  localparam logic [1:0] SCLK_W_DIV8    = 2'h0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ          = 50000000;
  localparam longint TICK_PERIOD_MS  = 500;
  localparam longint TICK_CYCLES     = (CLK_HZ * TICK_PERIOD_MS) / (1000 * 256);
  localparam longint WAIT_STATES_131K = 131072;
  localparam longint WAIT_STATES_DEF  = 8192;
  typedef enum logic [1:0] {PDM_ACTIVE, PDM_SLEEP, PDM_SUBACTIVE, PDM_WAIT} pdm_mode_e;
endpackage
`default_nettype wire

// *** rtl/pdm_ctrl.sv ***
// power-mode controller: sleep/subactive/active sequencing, timer time base, irq flags, port pin
//
// Decided for this implementation: the address-and-strobe port.
`default_nettype none
module pdm_ctrl #(
  parameter longint TICK_CYC  = pdm_pkg::TICK_CYCLES,
  parameter longint WAIT_LONG = pdm_pkg::WAIT_STATES_131K,
  parameter longint WAIT_DEF  = pdm_pkg::WAIT_STATES_DEF,
  parameter int     IRQ_SRCS  = 4
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                external_init_pin_n,
  input  wire logic [15:0]         reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  input  wire logic                sleep_exec,
  input  wire logic [IRQ_SRCS-1:0] ext_irq,
  output logic                     core_halt,
  output logic                     core_irq,
  output logic                     core_reset,
  output logic                     port7_pin4_out,
  output logic                     port7_pin4_oe,
  output logic [2:0]               active_clock_sel,
  output logic [1:0]               subactive_clock_sel,
  output logic                     low_speed_core
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]          tmr_mode;
    logic [7:0]          tmr_cnt;
    logic [31:0]         presc;
    logic [7:0]          p7_data;
    logic [7:0]          p7_dir;
    logic [7:0]          sc1;
    logic [7:0]          sc2;
    logic [7:0]          ien1;
    logic                flag_dt;
    logic                flag_ta;
    logic                imask;
    pdm_pkg::pdm_mode_e  mode;
    pdm_pkg::pdm_mode_e  wake_to;
    logic [31:0]         wait_cnt;
    logic [1:0]          pin_sync;
    logic                in_reset;
    logic [7:0]          rdata;
    logic                halt;
    logic                irq;
    logic                rst_out;
    logic                pin_out;
    logic                pin_oe;
    logic                low_spd;
  } pdm_state_s;

  pdm_state_s st_r;
  pdm_state_s st_nxt;

  // wait length from select field; values other than 100 use the default
  function automatic logic [31:0] wait_len(input logic [2:0] sel);
    if (sel == pdm_pkg::WAIT_SEL_131K) begin
      wait_len = 32'(WAIT_LONG);
    end else begin
      wait_len = 32'(WAIT_DEF);
    end
  endfunction

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  logic       standby_bit;
  logic [2:0] wait_sel;
  logic       sleep_kind;
  logic       low_speed;
  logic       direct_on;
  logic       ta_pending;
  logic       dt_pending;
  logic       ext_pending;
  logic       wake_req;
  logic       pin_low;

  assign standby_bit = st_r.sc1[pdm_pkg::SC1_STANDBY_BIT];
  assign wait_sel    = st_r.sc1[pdm_pkg::SC1_WAIT_HI:pdm_pkg::SC1_WAIT_LO];
  assign sleep_kind  = st_r.sc2[pdm_pkg::SC2_SLEEP_KIND];
  assign low_speed   = st_r.sc2[pdm_pkg::SC2_LOW_SPEED];
  assign direct_on   = st_r.sc2[pdm_pkg::SC2_DIRECT];
  // timer flags gated by their enables; external sources ungated; all by the core mask
  assign ta_pending  = st_r.flag_ta & st_r.ien1[pdm_pkg::IRQ_TA_BIT];
  assign dt_pending  = st_r.flag_dt & st_r.ien1[pdm_pkg::IRQ_DT_BIT];
  assign ext_pending = |ext_irq;
  assign wake_req    = ~st_r.imask & (ta_pending | dt_pending | ext_pending);
  assign pin_low     = ~st_r.pin_sync[1];

  always_comb begin
    st_nxt = st_r;
    // ----------------------------------------------------------------
    // reset pin synchroniser
    // ----------------------------------------------------------------
    st_nxt.pin_sync = {st_r.pin_sync[0], external_init_pin_n};
    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    st_nxt.rdata = 8'h00;
    if (reg_rd) begin
      if (hit(reg_addr, pdm_pkg::OFS_TMR_MODE)) st_nxt.rdata = st_r.tmr_mode;
      if (hit(reg_addr, pdm_pkg::OFS_TMR_CNT))  st_nxt.rdata = st_r.tmr_cnt;
      if (hit(reg_addr, pdm_pkg::OFS_P7_DATA))  st_nxt.rdata = st_r.p7_data;
      if (hit(reg_addr, pdm_pkg::OFS_P7_DIR))   st_nxt.rdata = st_r.p7_dir;
      if (hit(reg_addr, pdm_pkg::OFS_SYSCTL1))  st_nxt.rdata = st_r.sc1;
      if (hit(reg_addr, pdm_pkg::OFS_SYSCTL2))  st_nxt.rdata = st_r.sc2;
      if (hit(reg_addr, pdm_pkg::OFS_IRQ_EN1))  st_nxt.rdata = st_r.ien1;
      if (hit(reg_addr, pdm_pkg::OFS_IRQ_REQ1)) begin
        st_nxt.rdata = {st_r.flag_dt, st_r.flag_ta, 6'h00};
      end
      if (hit(reg_addr, pdm_pkg::OFS_CORE_CTL)) st_nxt.rdata = {6'h00, st_r.imask, 1'b0};
      if (hit(reg_addr, pdm_pkg::OFS_STATUS))   st_nxt.rdata = {6'h00, 2'(st_r.mode)};
    end
    if (reg_wr) begin
      if (hit(reg_addr, pdm_pkg::OFS_TMR_MODE)) st_nxt.tmr_mode = reg_wdata;
      if (hit(reg_addr, pdm_pkg::OFS_P7_DATA))  st_nxt.p7_data  = reg_wdata;
      if (hit(reg_addr, pdm_pkg::OFS_P7_DIR))   st_nxt.p7_dir   = reg_wdata;
      if (hit(reg_addr, pdm_pkg::OFS_SYSCTL1))  st_nxt.sc1      = reg_wdata;
      if (hit(reg_addr, pdm_pkg::OFS_SYSCTL2))  st_nxt.sc2      = reg_wdata;
      if (hit(reg_addr, pdm_pkg::OFS_IRQ_EN1))  st_nxt.ien1     = reg_wdata;
      if (hit(reg_addr, pdm_pkg::OFS_CORE_CTL)) st_nxt.imask    = reg_wdata[pdm_pkg::CORE_IMASK_BIT];
      // flags clear on a 0 write only; a set in the same cycle wins
      if (hit(reg_addr, pdm_pkg::OFS_IRQ_REQ1)) begin
        if (!reg_wdata[pdm_pkg::IRQ_DT_BIT]) st_nxt.flag_dt = 1'b0;
        if (!reg_wdata[pdm_pkg::IRQ_TA_BIT]) st_nxt.flag_ta = 1'b0;
      end
    end
    // ----------------------------------------------------------------
    // timer time base: counter runs in every mode, sleep included
    // ----------------------------------------------------------------
    // sits after the bus so an overflow beats a clear in the same cycle
    if (st_r.tmr_mode == pdm_pkg::TMR_TIMEBASE) begin
      if (st_r.presc >= 32'(TICK_CYC - 1)) begin
        st_nxt.presc   = 32'h0000_0000;
        st_nxt.tmr_cnt = st_r.tmr_cnt + 8'h01;
        if (st_r.tmr_cnt == 8'hFF) begin
          st_nxt.flag_ta = 1'b1;
        end
      end else begin
        st_nxt.presc = st_r.presc + 32'h0000_0001;
      end
    end else begin
      st_nxt.presc = 32'h0000_0000;
    end
    // ----------------------------------------------------------------
    // mode sequencer
    // ----------------------------------------------------------------
    case (st_r.mode)
      pdm_pkg::PDM_ACTIVE: begin
        if (sleep_exec && !standby_bit && !sleep_kind && !direct_on) begin
          if (low_speed) begin
            st_nxt.mode    = pdm_pkg::PDM_SLEEP;
            st_nxt.wake_to = pdm_pkg::PDM_SUBACTIVE;
          end else begin
            st_nxt.mode    = pdm_pkg::PDM_SLEEP;
            st_nxt.wake_to = pdm_pkg::PDM_ACTIVE;
          end
        end
      end
      pdm_pkg::PDM_SLEEP: begin
        if (wake_req) begin
          st_nxt.mode = st_r.wake_to;
        end
      end
      pdm_pkg::PDM_SUBACTIVE: begin
        if (sleep_exec && !low_speed && direct_on) begin
          st_nxt.mode     = pdm_pkg::PDM_WAIT;
          st_nxt.wait_cnt = wait_len(wait_sel);
        end else if (sleep_exec && !standby_bit && !sleep_kind && !direct_on) begin
          st_nxt.mode    = pdm_pkg::PDM_SLEEP;
          st_nxt.wake_to = pdm_pkg::PDM_SUBACTIVE;
        end
      end
      pdm_pkg::PDM_WAIT: begin
        if (st_r.wait_cnt <= 32'h0000_0001) begin
          st_nxt.mode    = pdm_pkg::PDM_ACTIVE;
          st_nxt.flag_dt = 1'b1;
        end else begin
          st_nxt.wait_cnt = st_r.wait_cnt - 32'h0000_0001;
        end
      end
      default: begin
        st_nxt.mode = pdm_pkg::PDM_ACTIVE;
      end
    endcase
    // ----------------------------------------------------------------
    // reset pin: cancels sleep, core held until the pin rises
    // ----------------------------------------------------------------
    st_nxt.in_reset = pin_low;
    if (pin_low) begin
      st_nxt.mode = pdm_pkg::PDM_ACTIVE;
    end
    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    st_nxt.rst_out = pin_low;
    st_nxt.halt    = (st_nxt.mode == pdm_pkg::PDM_SLEEP) || (st_nxt.mode == pdm_pkg::PDM_WAIT);
    // handling starts only once sleep has ended
    st_nxt.irq     = wake_req && (st_nxt.mode != pdm_pkg::PDM_SLEEP) && !pin_low;
    st_nxt.pin_oe  = st_nxt.p7_dir[pdm_pkg::P7_PIN4];
    st_nxt.pin_out = st_nxt.p7_data[pdm_pkg::P7_PIN4];
    st_nxt.low_spd = (st_nxt.mode == pdm_pkg::PDM_SUBACTIVE);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r          <= '0;
      st_r.imask    <= pdm_pkg::RST_CORE_CTL[pdm_pkg::CORE_IMASK_BIT];
      st_r.pin_sync <= 2'h3;
      st_r.mode     <= pdm_pkg::PDM_ACTIVE;
      st_r.wake_to  <= pdm_pkg::PDM_ACTIVE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata           = st_r.rdata;
  assign core_halt           = st_r.halt;
  assign core_irq            = st_r.irq;
  assign core_reset          = st_r.rst_out;
  assign port7_pin4_out      = st_r.pin_out;
  assign port7_pin4_oe       = st_r.pin_oe;
  // clock selects feed the clock generator; undivided and w/8 codes in the package
  assign active_clock_sel    = st_r.sc2[pdm_pkg::SC2_ACLK_HI:pdm_pkg::SC2_ACLK_LO];
  assign subactive_clock_sel = st_r.sc2[pdm_pkg::SC2_SCLK_HI:pdm_pkg::SC2_SCLK_LO];
  assign low_speed_core      = st_r.low_spd;
endmodule
`default_nettype wire

// *** verif/pdm_ctrl_properties.sv ***
// port-level checker of the power-mode controller
`default_nettype none
module pdm_ctrl_properties (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        external_init_pin_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        sleep_exec,
  input wire logic        core_halt,
  input wire logic        core_irq,
  input wire logic        core_reset,
  input wire logic        port7_pin4_out,
  input wire logic        port7_pin4_oe,
  input wire logic [2:0]  active_clock_sel,
  input wire logic [1:0]  subactive_clock_sel,
  input wire logic        low_speed_core
);
  // ----------------------------------------------------------------
  // shadow of the control registers
  // ----------------------------------------------------------------
  logic [7:0] sc1_r;
  logic [7:0] sc2_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sc1_r <= 8'h00;
      sc2_r <= 8'h00;
    end else if (reg_wr && reg_addr == pdm_pkg::OFS_SYSCTL1) begin
      sc1_r <= reg_wdata;
    end else if (reg_wr && reg_addr == pdm_pkg::OFS_SYSCTL2) begin
      sc2_r <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_pin_oe;
    reg_wr && reg_addr == pdm_pkg::OFS_P7_DIR |=> port7_pin4_oe == $past(reg_wdata[4]);
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin enable wrong");
  property p_pin_out;
    reg_wr && reg_addr == pdm_pkg::OFS_P7_DATA |=> port7_pin4_out == $past(reg_wdata[4]);
  endproperty
  a_pin_out: assert property (p_pin_out) else $error("pin level wrong");
  property p_aclk;
    reg_wr && reg_addr == pdm_pkg::OFS_SYSCTL2 |=> active_clock_sel == $past(reg_wdata[4:2]);
  endproperty
  a_aclk: assert property (p_aclk) else $error("active clock select wrong");
  property p_sclk;
    reg_wr && reg_addr == pdm_pkg::OFS_SYSCTL2 |=> subactive_clock_sel == $past(reg_wdata[1:0]);
  endproperty
  a_sclk: assert property (p_sclk) else $error("subactive clock select wrong");
  property p_sleep_entry;
    sleep_exec && !core_halt && !low_speed_core && !core_reset && !sc1_r[7] && sc2_r[7:5] == 3'b010 |=> core_halt;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
  property p_reset_rise;
    $fell(external_init_pin_n) |-> ##[1:4] core_reset;
  endproperty
  a_reset_rise: assert property (p_reset_rise) else $error("reset not taken");
  property p_reset_halt;
    core_reset |=> !core_halt;
  endproperty
  a_reset_halt: assert property (p_reset_halt) else $error("sleep kept in reset");
  // wait lengths of 8 and 4 are the short counts the bench hands the design
  property p_direct;
    low_speed_core && !core_halt && sleep_exec && sc2_r[6:5] == 2'b01 && sc1_r[6:4] == 3'b100
      |=> core_halt [*8] ##1 (!core_halt && !low_speed_core);
  endproperty
  a_direct: assert property (p_direct) else $error("long direct transition wrong");
  property p_direct_def;
    low_speed_core && !core_halt && sleep_exec && sc2_r[6:5] == 2'b01 && sc1_r[6:4] != 3'b100
      |=> core_halt [*4] ##1 (!core_halt && !low_speed_core);
  endproperty
  a_direct_def: assert property (p_direct_def) else $error("short direct transition wrong");
  property p_wake;
    $fell(core_halt) && !core_reset && sc2_r[6] |-> low_speed_core && core_irq;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not to subactive with irq");
endmodule
bind pdm_ctrl pdm_ctrl_properties chk_u (
  .clk_sys, .rst_n, .external_init_pin_n, .reg_addr, .reg_wdata, .reg_wr, .sleep_exec, .core_halt, .core_irq,
  .core_reset, .port7_pin4_out, .port7_pin4_oe, .active_clock_sel, .subactive_clock_sel, .low_speed_core);
`default_nettype wire

// *** verif/pdm_ctrl_tb.sv ***
// self-checking bench of the power-mode controller
`default_nettype none
module pdm_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst_n, external_init_pin_n, reg_wr, reg_rd, sleep_exec;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rd_v;
  logic [3:0]  ext_irq;
  logic        core_halt, core_irq, core_reset, p_out, p_oe, low_speed_core;
  logic [2:0]  acs;
  logic [1:0]  scs;
  int          n_mismatch, total_checks, i;
  // short counts keep the run small
  pdm_ctrl #(.TICK_CYC(4), .WAIT_LONG(8), .WAIT_DEF(4), .IRQ_SRCS(4)) dut_u (
    .clk_sys, .rst_n, .external_init_pin_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_exec,
    .ext_irq, .core_halt, .core_irq, .core_reset, .port7_pin4_out(p_out), .port7_pin4_oe(p_oe),
    .active_clock_sel(acs), .subactive_clock_sel(scs), .low_speed_core);
  // ----------------------------------------------------------------
  // bus, sleep and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    rd_v = reg_rdata;
  endtask
  task automatic nap;
    @(posedge clk_sys);
    sleep_exec <= 1'b1;
    @(posedge clk_sys);
    sleep_exec <= 1'b0;
    @(negedge clk_sys);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [15:0] ad [5];
    logic [7:0]  vl [5];
    ad = '{pdm_pkg::OFS_P7_DATA, pdm_pkg::OFS_P7_DIR, pdm_pkg::OFS_SYSCTL1, pdm_pkg::OFS_SYSCTL2, pdm_pkg::OFS_IRQ_EN1};
    vl = '{8'h10, 8'h10, 8'h40, 8'h4C, 8'hC0};
    rd(pdm_pkg::OFS_CORE_CTL);
    chk("mask", rd_v, 8'h02);
    for (int k = 0; k < 5; k++) begin
      rd(ad[k]);
      chk("reset value", rd_v, 8'h00);
      wr(ad[k], vl[k]);
      rd(ad[k]);
      chk("readback", rd_v, vl[k]);
    end
    chk("pin", {6'h00, p_out, p_oe}, 8'h03);
    wr(pdm_pkg::OFS_P7_DATA, 8'h00);
    @(negedge clk_sys);
    chk("pin low", {6'h00, p_out, p_oe}, 8'h01);
    chk("active clock", {5'h00, acs}, {5'h00, pdm_pkg::ACLK_UNDIVIDED});
    chk("sub clock", {6'h00, scs}, {6'h00, pdm_pkg::SCLK_W_DIV8});
    wr(pdm_pkg::OFS_TMR_CNT, 8'h55);
    rd(pdm_pkg::OFS_TMR_CNT);
    chk("counter", rd_v, 8'h00);
    wr(16'hFFF2, 8'h55);
    rd(16'hFFF2);
    chk("unmapped", rd_v, 8'h00);
  endtask
  // timer flag rises while disabled; sleep must hold until enabled
  task automatic t_wake;
    wr(pdm_pkg::OFS_IRQ_EN1, 8'h00);
    wr(pdm_pkg::OFS_TMR_MODE, pdm_pkg::TMR_TIMEBASE);
    wr(pdm_pkg::OFS_CORE_CTL, 8'h00);
    nap;
    chk("halted", {7'h00, core_halt}, 8'h01);
    repeat (1100) @(posedge clk_sys);
    rd(pdm_pkg::OFS_IRQ_REQ1);
    chk("timer flag", rd_v, 8'h40);
    rd(pdm_pkg::OFS_STATUS);
    chk("asleep", rd_v, 8'h01);
    wr(pdm_pkg::OFS_IRQ_EN1, 8'h40);
    for (i = 0; i < 10 && core_halt === 1'b1; i++) @(negedge clk_sys);
    chk("woken", {6'h00, core_halt, low_speed_core}, 8'h01);
    chk("irq", {7'h00, core_irq}, 8'h01);
    wr(pdm_pkg::OFS_IRQ_REQ1, 8'hBF);
    rd(pdm_pkg::OFS_IRQ_REQ1);
    chk("flag clear", rd_v, 8'h00);
  endtask
  // long wait select is 8 cycles with the bench's parameters
  task automatic t_direct;
    wr(pdm_pkg::OFS_IRQ_EN1, 8'h80);
    wr(pdm_pkg::OFS_SYSCTL1, 8'hC0);
    wr(pdm_pkg::OFS_SYSCTL2, 8'h2C);
    nap;
    for (i = 0; i < 40 && core_halt === 1'b1; i++) @(negedge clk_sys);
    chk("wait", {7'h00, i == 8}, 8'h01);
    chk("active", {7'h00, low_speed_core}, 8'h00);
    rd(pdm_pkg::OFS_IRQ_REQ1);
    chk("direct flag", rd_v, 8'h80);
    chk("direct irq", {7'h00, core_irq}, 8'h01);
    wr(pdm_pkg::OFS_IRQ_REQ1, 8'h7F);
    rd(pdm_pkg::OFS_IRQ_REQ1);
    chk("direct clear", rd_v, 8'h00);
  endtask
  task automatic t_reset;
    wr(pdm_pkg::OFS_IRQ_EN1, 8'h00);
    wr(pdm_pkg::OFS_SYSCTL1, 8'h00);
    wr(pdm_pkg::OFS_SYSCTL2, 8'h4C);
    nap;
    chk("asleep", {7'h00, core_halt}, 8'h01);
    @(posedge clk_sys);
    // held low well past the synchroniser, standing in for oscillator start-up
    external_init_pin_n <= 1'b0;
    for (i = 0; i < 10 && core_reset !== 1'b1; i++) @(negedge clk_sys);
    chk("reset in", {6'h00, core_reset, core_halt}, 8'h02);
    repeat (8) @(posedge clk_sys);
    external_init_pin_n <= 1'b1;
    for (i = 0; i < 10 && core_reset === 1'b1; i++) @(negedge clk_sys);
    chk("reset out", {6'h00, core_reset, core_halt}, 8'h00);
  endtask
  // masked source holds sleep, unmasked one wakes it; short wait select
  task automatic t_ext;
    wr(pdm_pkg::OFS_CORE_CTL, 8'h02);
    wr(pdm_pkg::OFS_SYSCTL2, 8'h0C);
    nap;
    @(posedge clk_sys);
    ext_irq <= 4'h8;
    repeat (4) @(negedge clk_sys);
    chk("masked", {6'h00, core_halt, core_irq}, 8'h02);
    wr(pdm_pkg::OFS_CORE_CTL, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk("ext wake", {5'h00, core_halt, low_speed_core, core_irq}, 8'h01);
    wr(pdm_pkg::OFS_SYSCTL2, 8'h4C);
    nap;
    @(negedge clk_sys);
    chk("ext to sub", {6'h00, core_halt, low_speed_core}, 8'h01);
    @(posedge clk_sys);
    ext_irq <= 4'h0;
    wr(pdm_pkg::OFS_SYSCTL1, 8'h80);
    wr(pdm_pkg::OFS_SYSCTL2, 8'h2C);
    nap;
    for (i = 0; i < 40 && core_halt === 1'b1; i++) @(negedge clk_sys);
    chk("short wait", {6'h00, i == 4, low_speed_core}, 8'h02);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    #400000;
    n_mismatch++;
    test_done;
  end
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    rst_n = 1'b0;
    external_init_pin_n = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep_exec = 1'b0;
    ext_irq = 4'h0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs;
    t_wake;
    t_direct;
    t_reset;
    t_ext;
    test_done;
  end
endmodule
`default_nettype wire
